// >>> include/mps_defines.svh
// Register offsets, field positions and timing constants of the motor startup config bank.
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

`define MPS_ADDR_W            8
`define MPS_WORD_W            17
`define MPS_ADDR_STARTUP      8'h4d
`define MPS_ADDR_TACH         8'h4e
`define MPS_ADDR_BRAKE        8'h4f
`define MPS_ADDR_SLEW         8'h50
`define MPS_ADDR_HOST         8'h51
`define MPS_WORD_RESET        17'h0_0000

`define MPS_STARTUP_DELAY_BIT 14
`define MPS_TACH_DIS_BIT      4
`define MPS_SAFE_BRAKE_MSB    16
`define MPS_SAFE_BRAKE_LSB    14
`define MPS_DEADTIME_MSB      11
`define MPS_DEADTIME_LSB      8
`define MPS_SOFT_ON_BIT       7
`define MPS_SOFT_OFF_BIT      6
`define MPS_ANGLE_MSB         3
`define MPS_ANGLE_LSB         2
`define MPS_STALL_MSB         13
`define MPS_STALL_LSB         12
`define MPS_FALL_MSB          11
`define MPS_FALL_LSB          10
`define MPS_RISE_MSB          9
`define MPS_RISE_LSB          8
`define MPS_ALIGN_MSB         7
`define MPS_ALIGN_LSB         6
`define MPS_BLANK_MSB         5
`define MPS_BLANK_LSB         4
`define MPS_RECOVERY_BIT      3
`define MPS_OCSEL_MSB         2
`define MPS_OCSEL_LSB         0
`define MPS_HOST_CMD_BIT      9
`define MPS_DEMAND_MSB        8
`define MPS_DEMAND_LSB        0

`define MPS_CLK_PERIOD_NS     100
`define MPS_DELAY_SHORT_MS    25
`define MPS_DELAY_LONG_MS     100
`define MPS_RESTART_S         5
`define MPS_BLANK1_NS         320
`define MPS_BLANK2_NS         640
`define MPS_BLANK3_NS         1280
`define MPS_FILTER_STEP_NS    120
`define MPS_FILTER_MAX_NS     480
`define MPS_DEADTIME_ZERO_NS  640
`define MPS_DEADTIME_STEP_NS  40
`define MPS_ANGLE1_DEG        5
`define MPS_ANGLE2_DEG        9
`define MPS_ANGLE3_DEG        13
`define MPS_ALIGN0_MS         1810
`define MPS_ALIGN1_MS         910
`define MPS_ALIGN2_MS         450
`define MPS_ALIGN3_MS         230
`define MPS_OCSEL_LS_ONLY     3'h5

`endif

// >>> include/mps_pkg.sv
// Types shared by the motor startup config bank.
package mps_pkg;
   typedef enum logic [1:0] {
      MPS_ST_IDLE = 2'b00,
      MPS_ST_WAIT = 2'b01,
      MPS_ST_RUN  = 2'b10
   } mps_start_state_t;
   typedef logic [16:0] mps_word_t;
endpackage : mps_pkg

// >>> src/mps_config_bank.sv
// Configuration shadow words and the startup, tach, brake and overcurrent logic they steer.
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"

module mps_config_bank #(
   parameter int SHORT_DELAY_CYC = `MPS_DELAY_SHORT_MS * (1000000 / `MPS_CLK_PERIOD_NS),
   parameter int LONG_DELAY_CYC  = `MPS_DELAY_LONG_MS * (1000000 / `MPS_CLK_PERIOD_NS),
   parameter int RESTART_CYC     = `MPS_RESTART_S * (1000000000 / `MPS_CLK_PERIOD_NS)
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic [`MPS_ADDR_W-1:0]  reg_addr,
   input  wire mps_pkg::mps_word_t      reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output var  mps_pkg::mps_word_t      reg_rdata_q,
   output logic                         reg_rvalid_q,
   output logic                         reg_wack_q,
   input  wire logic                    start_cmd,
   input  wire logic                    align_go_mode,
   input  wire logic                    supply_ok_pin,
   output logic                         startup_go_q,
   output logic                         supply_timeout_q,
   input  wire logic                    tach_in,
   output logic                         tach_output_q,
   input  wire logic [10:0]             motor_current,
   input  wire logic [10:0]             rated_current,
   input  wire logic                    brake_always,
   output logic                         brake_allow_q,
   output logic [9:0]                   deadtime_ns_q,
   input  wire logic                    windmill_start,
   input  wire logic                    motor_stopping,
   output logic                         soft_start_ramp_q,
   output logic                         soft_stop_ramp_q,
   input  wire logic                    startup_phase,
   input  wire logic [7:0]              angle_error_deg,
   output logic                         startup_lock_q,
   output logic [1:0]                   backemf_stall_filter_q,
   output logic                         backemf_lock_en_q,
   output logic [1:0]                   fall_slew_q,
   output logic [1:0]                   rise_slew_q,
   output logic [10:0]                  align_time_ms_q,
   input  wire logic                    out_transition,
   input  wire logic                    oc_hs_pin,
   input  wire logic                    oc_ls_pin,
   output logic                         oc_fault_q,
   output logic                         oc_auto_restart_q,
   input  wire logic [8:0]              pin_command,
   output logic                         host_mode_q,
   output logic [8:0]                   command_q
);
   import mps_pkg::*;

   localparam int P = `MPS_CLK_PERIOD_NS;
   localparam logic [3:0] BLANK1_CYC = 4'((`MPS_BLANK1_NS + P - 1) / P);
   localparam logic [3:0] BLANK2_CYC = 4'((`MPS_BLANK2_NS + P - 1) / P);
   localparam logic [3:0] BLANK3_CYC = 4'((`MPS_BLANK3_NS + P - 1) / P);
   localparam logic [2:0] FSTEP1_CYC = 3'((1 * `MPS_FILTER_STEP_NS + P - 1) / P);
   localparam logic [2:0] FSTEP2_CYC = 3'((2 * `MPS_FILTER_STEP_NS + P - 1) / P);
   localparam logic [2:0] FSTEP3_CYC = 3'((3 * `MPS_FILTER_STEP_NS + P - 1) / P);
   localparam logic [2:0] FMAX_CYC   = 3'((`MPS_FILTER_MAX_NS + P - 1) / P);

   mps_word_t        startup_word_q, tach_word_q, brake_word_q, slew_word_q, host_word_q;
   mps_start_state_t st_q;
   logic [25:0]      delay_cnt_q;
   logic [25:0]      delay_lim;
   logic [25:0]      restart_cnt_q;
   logic             written_q;
   logic [3:0]       sync1_q, sync2_q;
   logic             tach_s, supply_ok_s, oc_hs_s, oc_ls_s;
   logic [3:0]       blank_cnt_q;
   logic [3:0]       blank_cyc;
   logic [2:0]       filt_cnt_q;
   logic [2:0]       filt_cyc;
   logic             hs_en;
   logic             oc_seen;
   logic             wr_hit;
   logic [10:0]      brake_limit;
   logic [3:0]       angle_lim;
   logic [3:0]       dead_code;

   // Register port: one write per strobe, matched addresses acknowledged.
   assign wr_hit = reg_wr && (reg_addr == `MPS_ADDR_STARTUP || reg_addr == `MPS_ADDR_TACH ||
                              reg_addr == `MPS_ADDR_BRAKE || reg_addr == `MPS_ADDR_SLEW ||
                              reg_addr == `MPS_ADDR_HOST);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         startup_word_q <= `MPS_WORD_RESET;
         tach_word_q    <= `MPS_WORD_RESET;
         brake_word_q   <= `MPS_WORD_RESET;
         slew_word_q    <= `MPS_WORD_RESET;
         host_word_q    <= `MPS_WORD_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `MPS_ADDR_STARTUP: startup_word_q <= reg_wdata;
            `MPS_ADDR_TACH:    tach_word_q    <= reg_wdata;
            `MPS_ADDR_BRAKE:   brake_word_q   <= reg_wdata;
            `MPS_ADDR_SLEW:    slew_word_q    <= reg_wdata;
            `MPS_ADDR_HOST:    host_word_q    <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_q  <= `MPS_WORD_RESET;
         reg_rvalid_q <= 1'b0;
         reg_wack_q   <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         reg_wack_q   <= wr_hit;
         if (reg_rd) begin
            case (reg_addr)
               `MPS_ADDR_STARTUP: reg_rdata_q <= startup_word_q;
               `MPS_ADDR_TACH:    reg_rdata_q <= tach_word_q;
               `MPS_ADDR_BRAKE:   reg_rdata_q <= brake_word_q;
               `MPS_ADDR_SLEW:    reg_rdata_q <= slew_word_q;
               `MPS_ADDR_HOST:    reg_rdata_q <= host_word_q;
               default:           reg_rdata_q <= `MPS_WORD_RESET;
            endcase
         end
      end
   end

   // The tach, supply and overcurrent pin inputs pass two flops; only the second stage is read.
   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            sync1_q[gi] <= 1'b0;
            sync2_q[gi] <= 1'b0;
         end else begin
            sync1_q[gi] <= (gi == 0) ? tach_in : (gi == 1) ? supply_ok_pin :
                           (gi == 2) ? oc_hs_pin : oc_ls_pin;
            sync2_q[gi] <= sync1_q[gi];
         end
      end
   end
   assign tach_s      = sync2_q[0];
   assign supply_ok_s = sync2_q[1];
   assign oc_hs_s     = sync2_q[2];
   assign oc_ls_s     = sync2_q[3];

   // Startup settle window; align-and-go bypasses it.
   assign delay_lim = startup_word_q[`MPS_STARTUP_DELAY_BIT] ? 26'(LONG_DELAY_CYC) :
                                                              26'(SHORT_DELAY_CYC);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q             <= MPS_ST_IDLE;
         delay_cnt_q      <= 26'h000_0000;
         startup_go_q     <= 1'b0;
         supply_timeout_q <= 1'b0;
      end else begin
         startup_go_q <= 1'b0;
         case (st_q)
            MPS_ST_IDLE, MPS_ST_RUN: begin
               if (start_cmd) begin
                  supply_timeout_q <= 1'b0;
                  delay_cnt_q      <= 26'h000_0000;
                  if (align_go_mode) begin
                     st_q         <= MPS_ST_RUN;
                     startup_go_q <= 1'b1;
                  end else begin
                     st_q <= MPS_ST_WAIT;
                  end
               end
            end
            MPS_ST_WAIT: begin
               if (supply_ok_s) begin
                  st_q         <= MPS_ST_RUN;
                  startup_go_q <= 1'b1;
               end else if (delay_cnt_q >= delay_lim - 26'h000_0001) begin
                  st_q             <= MPS_ST_IDLE;
                  supply_timeout_q <= 1'b1;
               end else begin
                  delay_cnt_q <= delay_cnt_q + 26'h000_0001;
               end
            end
            default: st_q <= MPS_ST_IDLE;
         endcase
      end
   end

   // The tach pin is given up for good once software has written the bank.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         written_q     <= 1'b0;
         tach_output_q <= 1'b0;
      end else begin
         if (wr_hit) begin
            written_q <= 1'b1;
         end
         tach_output_q <= tach_s && !written_q && !wr_hit &&
                          !tach_word_q[`MPS_TACH_DIS_BIT];
      end
   end

   // Decoded settings for the drive stage.
   assign brake_limit = rated_current >> brake_word_q[`MPS_SAFE_BRAKE_MSB:`MPS_SAFE_BRAKE_LSB];
   assign dead_code   = brake_word_q[`MPS_DEADTIME_MSB:`MPS_DEADTIME_LSB];
   always_comb begin
      case (brake_word_q[`MPS_ANGLE_MSB:`MPS_ANGLE_LSB])
         2'h1:    angle_lim = 4'(`MPS_ANGLE1_DEG);
         2'h2:    angle_lim = 4'(`MPS_ANGLE2_DEG);
         2'h3:    angle_lim = 4'(`MPS_ANGLE3_DEG);
         default: angle_lim = 4'h0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         brake_allow_q     <= 1'b0;
         deadtime_ns_q     <= 10'(`MPS_DEADTIME_ZERO_NS);
         soft_start_ramp_q <= 1'b0;
         soft_stop_ramp_q  <= 1'b0;
         startup_lock_q    <= 1'b0;
      end else begin
         brake_allow_q <= brake_always || (motor_current < brake_limit);
         deadtime_ns_q <= (dead_code == 4'h0) ? 10'(`MPS_DEADTIME_ZERO_NS) :
                          10'((dead_code + 4'h1) * `MPS_DEADTIME_STEP_NS);
         soft_start_ramp_q <= brake_word_q[`MPS_SOFT_ON_BIT] && windmill_start;
         soft_stop_ramp_q  <= brake_word_q[`MPS_SOFT_OFF_BIT] && motor_stopping;
         startup_lock_q    <= startup_phase && (angle_lim != 4'h0) &&
                              (angle_error_deg > {4'h0, angle_lim});
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         backemf_stall_filter_q <= 2'h0;
         backemf_lock_en_q      <= 1'b0;
         fall_slew_q            <= 2'h0;
         rise_slew_q            <= 2'h0;
         align_time_ms_q        <= 11'(`MPS_ALIGN0_MS);
      end else begin
         backemf_stall_filter_q <= slew_word_q[`MPS_STALL_MSB:`MPS_STALL_LSB];
         backemf_lock_en_q      <= slew_word_q[`MPS_STALL_MSB:`MPS_STALL_LSB] != 2'h0;
         fall_slew_q            <= slew_word_q[`MPS_FALL_MSB:`MPS_FALL_LSB];
         rise_slew_q            <= slew_word_q[`MPS_RISE_MSB:`MPS_RISE_LSB];
         case (slew_word_q[`MPS_ALIGN_MSB:`MPS_ALIGN_LSB])
            2'h1:    align_time_ms_q <= 11'(`MPS_ALIGN1_MS);
            2'h2:    align_time_ms_q <= 11'(`MPS_ALIGN2_MS);
            2'h3:    align_time_ms_q <= 11'(`MPS_ALIGN3_MS);
            default: align_time_ms_q <= 11'(`MPS_ALIGN0_MS);
         endcase
      end
   end

   // Overcurrent: blanking, then a filter of consecutive cycles before the fault.
   always_comb begin
      case (slew_word_q[`MPS_BLANK_MSB:`MPS_BLANK_LSB])
         2'h1:    blank_cyc = BLANK1_CYC;
         2'h2:    blank_cyc = BLANK2_CYC;
         2'h3:    blank_cyc = BLANK3_CYC;
         default: blank_cyc = 4'h0;
      endcase
      case (slew_word_q[`MPS_OCSEL_MSB:`MPS_OCSEL_LSB])
         3'h0:    filt_cyc = 3'h0;
         3'h1:    filt_cyc = FSTEP1_CYC;
         3'h2:    filt_cyc = FSTEP2_CYC;
         3'h3:    filt_cyc = FSTEP3_CYC;
         default: filt_cyc = FMAX_CYC;
      endcase
   end
   assign hs_en   = slew_word_q[`MPS_OCSEL_MSB:`MPS_OCSEL_LSB] != `MPS_OCSEL_LS_ONLY;
   assign oc_seen = (oc_hs_s && hs_en) || oc_ls_s;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         blank_cnt_q <= 4'h0;
      end else if (out_transition) begin
         blank_cnt_q <= blank_cyc;
      end else if (blank_cnt_q != 4'h0) begin
         blank_cnt_q <= blank_cnt_q - 4'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         filt_cnt_q <= 3'h0;
      end else if (!oc_seen || out_transition || blank_cnt_q != 4'h0) begin
         filt_cnt_q <= 3'h0;
      end else if (filt_cnt_q < filt_cyc) begin
         filt_cnt_q <= filt_cnt_q + 3'h1;
      end
   end

   // A new trip in the clearing cycle keeps the fault set.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         oc_fault_q        <= 1'b0;
         restart_cnt_q     <= 26'h000_0000;
         oc_auto_restart_q <= 1'b0;
      end else begin
         oc_auto_restart_q <= 1'b0;
         if (oc_seen && !out_transition && blank_cnt_q == 4'h0 && filt_cnt_q >= filt_cyc) begin
            oc_fault_q    <= 1'b1;
            restart_cnt_q <= 26'h000_0000;
         end else if (oc_fault_q) begin
            if (!slew_word_q[`MPS_RECOVERY_BIT]) begin
               restart_cnt_q <= 26'h000_0000;
               if (start_cmd) begin
                  oc_fault_q <= 1'b0;
               end
            end else if (restart_cnt_q >= 26'(RESTART_CYC) - 26'h000_0001) begin
               oc_fault_q        <= 1'b0;
               oc_auto_restart_q <= 1'b1;
               restart_cnt_q     <= 26'h000_0000;
            end else begin
               restart_cnt_q <= restart_cnt_q + 26'h000_0001;
            end
         end
      end
   end

   // Command source select.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         host_mode_q <= 1'b0;
         command_q   <= 9'h000;
      end else begin
         host_mode_q <= host_word_q[`MPS_HOST_CMD_BIT];
         command_q   <= host_word_q[`MPS_HOST_CMD_BIT] ?
                        host_word_q[`MPS_DEMAND_MSB:`MPS_DEMAND_LSB] : pin_command;
      end
   end

   sequence trip_s;
      oc_seen && !out_transition && blank_cnt_q == 4'h0 && filt_cnt_q >= filt_cyc;
   endsequence

   tach_after_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      wr_hit |=> ##1 !tach_output_q)
      else $error("tach output active after a register write");
   settle_timeout_a: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == MPS_ST_WAIT && !supply_ok_s && delay_cnt_q == delay_lim - 26'h000_0001)
      |=> supply_timeout_q && st_q == MPS_ST_IDLE)
      else $error("settle window did not time out");
   brake_check_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!brake_always && motor_current >= brake_limit) |=> !brake_allow_q)
      else $error("brake allowed above threshold");
   deadtime_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      (dead_code == 4'h0) |=> deadtime_ns_q == 10'(`MPS_DEADTIME_ZERO_NS))
      else $error("deadtime code zero wrong");
   blank_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
      (out_transition && blank_cyc != 4'h0 && !oc_fault_q) |=> !oc_fault_q)
      else $error("fault raised inside blanking");
   filter_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
      ($rose(oc_fault_q)) |-> $past(filt_cnt_q) >= $past(filt_cyc))
      else $error("fault raised before filter time");
   fault_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      trip_s |=> oc_fault_q)
      else $error("trip not latched");
   manual_recover_a: assert property (@(posedge ref_clk) disable iff (rst)
      (oc_fault_q && !slew_word_q[`MPS_RECOVERY_BIT] && !start_cmd && !trip_s) |=> oc_fault_q)
      else $error("fault cleared without restart");
   host_select_a: assert property (@(posedge ref_clk) disable iff (rst)
      host_word_q[`MPS_HOST_CMD_BIT] |=> command_q == $past(host_word_q[8:0]))
      else $error("host demand not selected");
   ls_only_a: assert property (@(posedge ref_clk) disable iff (rst)
      (slew_word_q[2:0] == `MPS_OCSEL_LS_ONLY) |-> !hs_en)
      else $error("high side enabled in low-side-only mode");

endmodule : mps_config_bank

`default_nettype wire

// >>> tb/mps_host_model.sv
// Host model that runs register write and read cycles on the config bank.
`timescale 1ns/1ps
`default_nettype none

module mps_host_model (
   input  wire logic               ref_clk,
   input  wire mps_pkg::mps_word_t reg_rdata_q,
   input  wire logic               reg_rvalid_q,
   input  wire logic               reg_wack_q,
   output logic [7:0]              reg_addr,
   output mps_pkg::mps_word_t      reg_wdata,
   output logic                    reg_wr,
   output logic                    reg_rd
);
   import mps_pkg::*;

   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 17'h0_0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // Released lines show the inverse so a stale value is never mistaken for a live one.
   task automatic write_word(input logic [7:0] a, input mps_word_t d, output logic acked);
      @(negedge ref_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
      acked     = reg_wack_q;
   endtask : write_word

   task automatic read_word(input logic [7:0] a, output mps_word_t d, output logic valid);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata_q;
      valid    = reg_rvalid_q;
   endtask : read_word
endmodule : mps_host_model

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the motor startup config bank.
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"

`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin bad_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end

module tb;
   import mps_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, ok, vld;
   logic [7:0] reg_addr, seed = 8'h44, ang;
   mps_word_t reg_wdata, reg_rdata_q, w, r;
   logic reg_wr, reg_rd, reg_rvalid_q, reg_wack_q, go, tmo, tach, brk, ss, sp, lk, lken, oc, ar, hm;
   logic start = 1'b0, algo = 1'b0, sup = 1'b0, tin = 1'b1, balw = 1'b0, wind = 1'b1;
   logic stop = 1'b1, tr = 1'b0, hs = 1'b0, ls = 1'b0, sph = 1'b1;
   logic [10:0] mcur = 11'h000, rcur = 11'h400, alt;
   logic [9:0] dt;
   logic [1:0] stf, fs, rs;
   logic [8:0] pin = 9'h0a5, cmd;
   int bad_count = 0, compares = 0, lat;

   always #50 ref_clk = ~ref_clk;

   mps_host_model host (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .reg_wack_q(reg_wack_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));

   mps_config_bank #(.SHORT_DELAY_CYC(20), .LONG_DELAY_CYC(40), .RESTART_CYC(30)) dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .reg_wack_q(reg_wack_q), .start_cmd(start), .align_go_mode(algo), .supply_ok_pin(sup),
      .startup_go_q(go), .supply_timeout_q(tmo), .tach_in(tin), .tach_output_q(tach),
      .motor_current(mcur), .rated_current(rcur), .brake_always(balw), .brake_allow_q(brk),
      .deadtime_ns_q(dt), .windmill_start(wind), .motor_stopping(stop),
      .soft_start_ramp_q(ss), .soft_stop_ramp_q(sp), .startup_phase(sph),
      .angle_error_deg(ang), .startup_lock_q(lk), .backemf_stall_filter_q(stf),
      .backemf_lock_en_q(lken), .fall_slew_q(fs), .rise_slew_q(rs), .align_time_ms_q(alt),
      .out_transition(tr), .oc_hs_pin(hs), .oc_ls_pin(ls), .oc_fault_q(oc),
      .oc_auto_restart_q(ar), .pin_command(pin), .host_mode_q(hm), .command_q(cmd));

   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr

   function automatic logic [9:0] dt_exp(input logic [3:0] c);
      return (c == 4'h0) ? 10'd640 : 10'((c + 1) * 40);
   endfunction : dt_exp

   function automatic logic [10:0] align_exp(input logic [1:0] c);
      return (c == 2'd0) ? 11'd1810 : (c == 2'd1) ? 11'd910 : (c == 2'd2) ? 11'd450 : 11'd230;
   endfunction : align_exp

   // Cycles from pin rise to a visible fault: two sync stages, blanking, then the filter.
   function automatic int oc_lat_exp(input logic [2:0] c);
      int b, f;
      b = (c[1:0] == 2'd0) ? 0 : ((`MPS_BLANK1_NS << (c[1:0] - 2'd1)) + 99) / 100;
      f = (c == 3'd0) ? 0 : (((c > 3'd4) ? 4 : int'(c)) * `MPS_FILTER_STEP_NS + 99) / 100;
      return ((b == 0) ? 3 : b + 2) + f;
   endfunction : oc_lat_exp

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc

   task automatic rnd(output mps_word_t v);
      seed = lfsr(seed);
      v[16:9] = seed;
      seed = lfsr(seed);
      v[8:1] = seed;
      v[0] = seed[3];
   endtask : rnd

   task automatic pulse_start();
      @(negedge ref_clk);
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
   endtask : pulse_start

   // Looks at once and then for at most n cycles, so a pulse already standing is not missed.
   task automatic wait_pulse(input int n, input int sel, output logic seen);
      seen = (sel == 0) ? go : ar;
      for (int i = 0; i < n && seen !== 1'b1; i++) begin
         @(negedge ref_clk);
         seen = (sel == 0) ? go : ar;
      end
   endtask : wait_pulse

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #3000000;
      bad_count++;
      final_report();
   end

   initial begin
      ang = 8'd0;
      cyc(20);
      rst = 1'b0;
      cyc(3);
      `CHK("deadtime_rst", 10'd640, dt)
      `CHK("align_rst", 11'd1810, alt)
      `CHK("tach_on", 1'b1, tach)
      tin = 1'b0;
      cyc(3);
      `CHK("tach_follow", 1'b0, tach)
      tin = 1'b1;
      for (logic [7:0] a = 8'h4d; a <= 8'h52; a++) begin
         host.read_word(a, r, vld);
         `CHK("rst_word", 17'h0_0000, r)
         `CHK("rvalid", 1'b1, vld)
      end
      host.write_word(8'h52, 17'h1_ffff, ok);
      `CHK("unmapped_wack", 1'b0, ok)
      host.read_word(8'h52, r, vld);
      `CHK("unmapped_read", 17'h0_0000, r)
      for (logic [7:0] a = 8'h4d; a <= 8'h51; a++) begin
         rnd(w);
         host.write_word(a, w, ok);
         `CHK("wack", 1'b1, ok)
         host.read_word(a, r, vld);
         `CHK("readback", w, r)
      end
      cyc(3);
      `CHK("tach_after_write", 1'b0, tach)
      for (int i = 0; i < 16; i++) begin
         rnd(w);
         w[11:8] = 4'(i);
         rcur = w[10:0];
         mcur = {w[16:12], w[5:0]};
         balw = w[5];
         stop = w[1];
         host.write_word(`MPS_ADDR_BRAKE, w, ok);
         cyc(3);
         `CHK("deadtime", dt_exp(w[11:8]), dt)
         `CHK("brake", balw | (mcur < (rcur >> w[16:14])), brk)
         `CHK("soft_on", w[7] & wind, ss)
         `CHK("soft_off", w[6] & stop, sp)
      end
      for (int i = 0; i < 4; i++) begin
         rnd(w);
         w[7:6] = 2'(i);
         w[5:0] = 6'h00;
         host.write_word(`MPS_ADDR_SLEW, w, ok);
         cyc(3);
         `CHK("stall", w[13:12], stf)
         `CHK("lock_en", w[13:12] != 2'd0, lken)
         `CHK("fall", w[11:10], fs)
         `CHK("rise", w[9:8], rs)
         `CHK("align", align_exp(w[7:6]), alt)
         w = {13'h0000, 2'(i), 2'b00};
         ang = 8'd9;
         host.write_word(`MPS_ADDR_BRAKE, w, ok);
         cyc(3);
         `CHK("angle_lock", w[3:2] == 2'd1, lk)
         sph = 1'b0;
         cyc(3);
         `CHK("lock_phase", 1'b0, lk)
         sph = 1'b1;
      end
      host.write_word(`MPS_ADDR_HOST, 17'h0_0123, ok);
      cyc(3);
      `CHK("pin_cmd", pin, cmd)
      `CHK("pin_mode", 1'b0, hm)
      for (int i = 0; i < 2; i++) begin
         host.write_word(`MPS_ADDR_HOST, {7'h00, 1'b1, (i == 0) ? 9'h1ff : 9'h000}, ok);
         cyc(3);
         `CHK("host_mode", 1'b1, hm)
         `CHK("demand", (i == 0) ? 9'h1ff : 9'h000, cmd)
      end
      host.write_word(`MPS_ADDR_STARTUP, 17'h0_0000, ok);
      pulse_start();
      cyc(15);
      `CHK("no_timeout_short", 1'b0, tmo)
      cyc(10);
      `CHK("timeout_short", 1'b1, tmo)
      host.write_word(`MPS_ADDR_STARTUP, 17'h0_4000, ok);
      pulse_start();
      cyc(33);
      `CHK("no_timeout_long", 1'b0, tmo)
      cyc(10);
      `CHK("timeout_long", 1'b1, tmo)
      algo = 1'b1;
      pulse_start();
      wait_pulse(3, 0, ok);
      `CHK("align_go", 1'b1, ok)
      algo = 1'b0;
      sup = 1'b1;
      pulse_start();
      wait_pulse(6, 0, ok);
      `CHK("supply_go", 1'b1, ok)
      host.write_word(`MPS_ADDR_SLEW, 17'h0_0019, ok);
      @(negedge ref_clk);
      hs = 1'b1;
      tr = 1'b1;
      @(negedge ref_clk);
      tr = 1'b0;
      cyc(3);
      `CHK("blanked", 1'b0, oc)
      cyc(10);
      `CHK("oc_trip", 1'b1, oc)
      hs = 1'b0;
      wait_pulse(45, 1, ok);
      `CHK("auto_restart", 1'b1, ok)
      cyc(1);
      `CHK("oc_cleared", 1'b0, oc)
      host.write_word(`MPS_ADDR_SLEW, 17'h0_0005, ok);
      hs = 1'b1;
      cyc(20);
      `CHK("hs_ignored", 1'b0, oc)
      ls = 1'b1;
      cyc(12);
      `CHK("ls_trip", 1'b1, oc)
      hs = 1'b0;
      ls = 1'b0;
      cyc(40);
      `CHK("oc_sticky", 1'b1, oc)
      pulse_start();
      cyc(2);
      `CHK("restart_clear", 1'b0, oc)
      host.write_word(`MPS_ADDR_SLEW, 17'h0_0006, ok);
      hs = 1'b1;
      cyc(12);
      `CHK("code110_hs", 1'b1, oc)
      hs = 1'b0;
      cyc(3);
      pulse_start();
      // Every blank and filter code, timed from the pin rise that comes with a transition.
      for (int i = 0; i < 8; i++) begin
         host.write_word(`MPS_ADDR_SLEW, {11'h000, 2'(i), 1'b0, 3'(i)}, ok);
         ls = 1'b1;
         tr = 1'b1;
         lat = 0;
         while (oc !== 1'b1 && lat < 30) begin
            @(negedge ref_clk);
            tr = 1'b0;
            lat++;
         end
         `CHK("oc_latency", oc_lat_exp(3'(i)), lat)
         ls = 1'b0;
         cyc(3);
         pulse_start();
      end
      final_report();
   end
endmodule : tb

`default_nettype wire
